// *** rtl/spio_pkg.sv ***
// Package with constants and carrier types for the shared parallel I/O port.
package spio_pkg;
    localparam int unsigned PORT_W = 16;
    // Which bits exist on this variant, and which carry an analog function.
    localparam logic [PORT_W-1:0] IMPL_MASK   = 16'hffff;
    localparam logic [PORT_W-1:0] ANALOG_MASK = 16'hffff;
    localparam logic [PORT_W-1:0] DIR_RESET   = 16'hffff;
    localparam logic [PORT_W-1:0] LAT_RESET   = 16'h0000;
    localparam logic [PORT_W-1:0] ODC_RESET   = 16'h0000;
    localparam logic [PORT_W-1:0] ASEL_RESET  = 16'h0000;
    localparam logic [PORT_W-1:0] ALL_ZERO    = 16'h0000;

    typedef enum logic [1:0] {
        SPIO_REG_LAT  = 2'h0,
        SPIO_REG_PORT = 2'h1,
        SPIO_REG_DIR  = 2'h2,
        SPIO_REG_ODC  = 2'h3
    } spio_reg_sel_t;

    typedef struct packed {
        logic [PORT_W-1:0] enable;
        logic [PORT_W-1:0] drive;
        logic [PORT_W-1:0] data;
    } spio_periph_t;

    typedef struct packed {
        logic [PORT_W-1:0] o;
        logic [PORT_W-1:0] oe;
    } spio_pad_t;
endpackage

// *** rtl/spio_port.sv ***
// Shared parallel I/O port bank with peripheral and analog pin sharing.
`timescale 1ns/1ps
module spio_port (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic                      wr_en,
    input  wire logic [1:0]                wr_sel,
    input  wire logic [spio_pkg::PORT_W-1:0] wr_data,
    input  wire logic [1:0]                rd_sel,
    output logic      [spio_pkg::PORT_W-1:0] rd_data,
    input  wire logic [spio_pkg::PORT_W-1:0] analog_select_low_reg,
    input  wire logic [spio_pkg::PORT_W-1:0] analog_select_high_reg,
    input  wire logic                      converter1_off_bit,
    input  wire logic                      converter2_off_bit,
    output logic      [spio_pkg::PORT_W-1:0] analog_pin,
    input  wire spio_pkg::spio_periph_t    periph,
    output logic      [spio_pkg::PORT_W-1:0] periph_in,
    input  wire logic [spio_pkg::PORT_W-1:0] pad_i,
    output spio_pkg::spio_pad_t            pad
);
    import spio_pkg::*;

    // Bits that the peripheral claims: enabled alone is not enough, it must drive.
    function automatic logic [PORT_W-1:0] spio_owned(input spio_periph_t p);
        return p.enable & p.drive;
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [PORT_W-1:0] dir_r, dir_nxt;
    logic [PORT_W-1:0] lat_r, lat_nxt;
    logic [PORT_W-1:0] odc_r, odc_nxt;
    logic [PORT_W-1:0] pin_s;

    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        odc_nxt = odc_r;
        if (wr_en) begin
            case (spio_reg_sel_t'(wr_sel))
                SPIO_REG_LAT:  lat_nxt = wr_data & IMPL_MASK;
                SPIO_REG_PORT: lat_nxt = wr_data & IMPL_MASK;
                SPIO_REG_DIR:  dir_nxt = wr_data & IMPL_MASK;
                SPIO_REG_ODC:  odc_nxt = wr_data & IMPL_MASK;
                default:       lat_nxt = lat_r;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dir_r <= DIR_RESET & IMPL_MASK;
            lat_r <= LAT_RESET;
            odc_r <= ODC_RESET;
        end else begin
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            odc_r <= odc_nxt;
        end
    end

    // Pins pass two flops before any read or peripheral sees them.
    spio_sync u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in (pad_i),
        .sync_out (pin_s)
    );

    // ------------------------------------------------------------
    // Analog selection and output muxing
    // ------------------------------------------------------------
    logic [PORT_W-1:0] an_c1, an_c2, an_c;
    logic [PORT_W-1:0] pin_in_nxt, o_nxt, oe_nxt, an_nxt;
    logic [PORT_W-1:0] pin_in_r, o_r, oe_r, an_r;
    logic [PORT_W-1:0] own_o, own_en;

    always_comb begin
        // A disabled converter contributes no analog claim.
        an_c1 = converter1_off_bit ? ALL_ZERO : ~analog_select_low_reg;
        an_c2 = converter2_off_bit ? ALL_ZERO : ~analog_select_high_reg;
        an_c  = (an_c1 | an_c2) & ANALOG_MASK & IMPL_MASK;
        an_nxt = an_c;
        // Peripheral takes the pin only while actively driving it.
        own_en = spio_owned(periph);
        // Owner is picked bit by bit, so an idle peripheral bit still shows the latch.
        own_o  = (own_en & periph.data) | (~own_en & lat_r);
        for (int i = 0; i < PORT_W; i++) begin
            if (own_en[i]) begin
                oe_nxt[i] = 1'b1;
                o_nxt[i]  = periph.data[i];
            end else begin
                // Open drain drives only a low level.
                oe_nxt[i] = ~dir_r[i] & (~odc_r[i] | ~lat_r[i]);
                o_nxt[i]  = odc_r[i] ? 1'b0 : own_o[i];
            end
        end
        oe_nxt = oe_nxt & IMPL_MASK & ~an_c;
        o_nxt  = o_nxt & oe_nxt;
        // Peripheral input sees the pin, never the port's own output.
        pin_in_nxt = pin_s & IMPL_MASK & ~an_c;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_in_r <= ALL_ZERO;
            o_r      <= ALL_ZERO;
            oe_r     <= ALL_ZERO;
            an_r     <= ANALOG_MASK & IMPL_MASK;
        end else begin
            pin_in_r <= pin_in_nxt;
            o_r      <= o_nxt;
            oe_r     <= oe_nxt;
            an_r     <= an_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [PORT_W-1:0] rd_nxt;
    logic [PORT_W-1:0] rd_r;

    // Reads are registered so that rd_data leaves a flop, at the cost of one
    // cycle of read latency on top of the two synchroniser stages.
    always_comb begin
        case (spio_reg_sel_t'(rd_sel))
            SPIO_REG_LAT:  rd_nxt = lat_r & IMPL_MASK;
            SPIO_REG_PORT: rd_nxt = pin_s & IMPL_MASK & ~an_c;
            SPIO_REG_DIR:  rd_nxt = dir_r & IMPL_MASK;
            SPIO_REG_ODC:  rd_nxt = odc_r & IMPL_MASK;
            default:       rd_nxt = ALL_ZERO;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_r <= ALL_ZERO;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign rd_data    = rd_r;
    assign periph_in  = pin_in_r;
    assign analog_pin = an_r;
    assign pad        = '{o: o_r, oe: oe_r};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    periph_owns_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (periph.enable & periph.drive & ~an_c) != ALL_ZERO |=>
        ((pad.o ^ $past(periph.data)) & $past(periph.enable & periph.drive & ~an_c)) == ALL_ZERO)
        else $error("peripheral data not on pad");
    port_owns_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (~(periph.enable & periph.drive) & ~dir_r & ~odc_r & ~an_c & IMPL_MASK) != ALL_ZERO |=>
        ((~pad.oe) & $past(~(periph.enable & periph.drive) & ~dir_r & ~odc_r & ~an_c
            & IMPL_MASK)) == ALL_ZERO)
        else $error("port driver not enabled");
    input_dir_a: assert property (@(posedge core_clk) disable iff (!resetn)
        ((pad.oe & $past(dir_r & ~(periph.enable & periph.drive))) == ALL_ZERO))
        else $error("input pin driven");
    lat_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_en && wr_sel == SPIO_REG_PORT ##1 rd_sel == SPIO_REG_LAT |=>
        rd_data == ($past(wr_data, 2) & IMPL_MASK))
        else $error("port write not in latch");
    unimpl_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rd_data & ~IMPL_MASK) == ALL_ZERO && (pad.oe & ~IMPL_MASK) == ALL_ZERO)
        else $error("unimplemented bit active");
    open_drain_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (pad.o & $past(odc_r & ~(periph.enable & periph.drive))) == ALL_ZERO)
        else $error("open drain drove high");
    analog_either_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !converter1_off_bit && !converter2_off_bit |=>
        analog_pin == ($past(~analog_select_low_reg | ~analog_select_high_reg) & ANALOG_MASK))
        else $error("analog merge wrong");
    analog_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_sel == SPIO_REG_PORT |=> (rd_data & $past(an_c)) == ALL_ZERO)
        else $error("analog pin read nonzero");
    conv_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        converter1_off_bit && converter2_off_bit |=> analog_pin == ALL_ZERO)
        else $error("disabled converter claimed pin");
    latch_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_en && wr_sel == SPIO_REG_LAT ##1 rd_sel == SPIO_REG_LAT |=>
        rd_data == ($past(wr_data, 2) & IMPL_MASK))
        else $error("latch write not read back");
    conv1_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        converter1_off_bit && !converter2_off_bit |=>
        analog_pin == ($past(~analog_select_high_reg) & ANALOG_MASK))
        else $error("converter one claim not ignored");
    conv2_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !converter1_off_bit && converter2_off_bit |=>
        analog_pin == ($past(~analog_select_low_reg) & ANALOG_MASK))
        else $error("converter two claim not ignored");
    // Analog pins are never driven, not even by an owning peripheral.
    analog_undriven_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (pad.oe & $past(an_c)) == ALL_ZERO)
        else $error("analog pin driven");
    open_float_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (pad.oe & $past(odc_r & lat_r & ~spio_owned(periph))) == ALL_ZERO)
        else $error("open drain high not floated");
    periph_analog_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (periph_in & $past(an_c)) == ALL_ZERO)
        else $error("analog pin reached peripheral");

    // ------------------------------------------------------------
    // Reset checks
    // ------------------------------------------------------------
    // These run through reset on purpose, so they carry no disable clause.
    reset_dir_a: assert property (@(posedge core_clk)
        !resetn |=> dir_r == (DIR_RESET & IMPL_MASK) && pad.oe == ALL_ZERO)
        else $error("pin not input after reset");
    reset_analog_a: assert property (@(posedge core_clk)
        !resetn |=> analog_pin == (ANALOG_MASK & IMPL_MASK))
        else $error("pin not analog after reset");
endmodule // spio_port

// *** rtl/spio_sync.sv ***
// Two-flip-flop synchroniser for the pin inputs.
`timescale 1ns/1ps
module spio_sync (
    input  wire logic                       core_clk,
    input  wire logic                       resetn,
    input  wire logic [spio_pkg::PORT_W-1:0] async_in,
    output logic      [spio_pkg::PORT_W-1:0] sync_out
);
    import spio_pkg::*;
    logic [PORT_W-1:0] meta_r;
    logic [PORT_W-1:0] sync_r;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= ALL_ZERO;
            sync_r <= ALL_ZERO;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end
    assign sync_out = sync_r;
endmodule // spio_sync

// *** testbench/spio_pins_model.sv ***
// Behavioural model of the external pins that surround the port bank.
`timescale 1ns/1ps
module spio_pins_model (
    input  wire spio_pkg::spio_pad_t          pad,
    input  wire logic [spio_pkg::PORT_W-1:0] ext_level,
    output logic      [spio_pkg::PORT_W-1:0] pad_i
);
    import spio_pkg::*;
    // An undriven or floated pin shows the board level, so a pull-up reads high.
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            pad_i[i] = pad.oe[i] ? pad.o[i] : ext_level[i];
        end
    end
endmodule // spio_pins_model

// *** testbench/spio_port_tb.sv ***
// Self-checking testbench for the shared parallel I/O port bank.
`timescale 1ns/1ps
module spio_port_tb;
    import spio_pkg::*;
    logic              core_clk  = 1'b0;
    logic              resetn    = 1'b0;
    logic              wr_en     = 1'b0;
    logic [1:0]        wr_sel    = 2'h0;
    logic [1:0]        rd_sel    = 2'h0;
    logic [PORT_W-1:0] wr_data   = 16'h0000;
    logic [PORT_W-1:0] asel_lo   = 16'h0000;
    logic [PORT_W-1:0] asel_hi   = 16'h0000;
    logic              c1_off    = 1'b0;
    logic              c2_off    = 1'b0;
    logic [PORT_W-1:0] ext_level = 16'hffff;
    spio_periph_t      periph    = '0;
    logic [PORT_W-1:0] rd_data;
    logic [PORT_W-1:0] analog_pin;
    logic [PORT_W-1:0] periph_in;
    logic [PORT_W-1:0] pad_i;
    spio_pad_t         pad;
    int                err_total   = 0;
    int                checks_done = 0;

    always #50 core_clk = ~core_clk;

    spio_port dut (.core_clk(core_clk), .resetn(resetn), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data),
        .analog_select_low_reg(asel_lo), .analog_select_high_reg(asel_hi),
        .converter1_off_bit(c1_off), .converter2_off_bit(c2_off), .analog_pin(analog_pin),
        .periph(periph), .periph_in(periph_in), .pad_i(pad_i), .pad(pad));
    spio_pins_model pins (.pad(pad), .ext_level(ext_level), .pad_i(pad_i));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [PORT_W-1:0] seen, input logic [PORT_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] sel, input logic [PORT_W-1:0] d);
        wr_en = 1'b1;
        wr_sel = sel;
        wr_data = d;
        @(negedge core_clk);
        wr_en = 1'b0;
        // One idle edge keeps a following write from re-raising the strobe at once.
        @(negedge core_clk);
    endtask

    // Six cycles cover the pad register, the two sync stages and the read register.
    task automatic rd(input logic [1:0] sel, input logic [PORT_W-1:0] exp);
        rd_sel = sel;
        repeat (6) @(negedge core_clk);
        chk(rd_data, exp);
    endtask

    task automatic wrap_up;
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        rd(SPIO_REG_DIR, DIR_RESET & IMPL_MASK);
        rd(SPIO_REG_LAT, LAT_RESET & IMPL_MASK);
        chk(analog_pin, ANALOG_MASK);
        chk(pad.oe, 16'h0000);
        asel_lo = 16'hffff;
        asel_hi = 16'hffff;
        wr(SPIO_REG_LAT, 16'ha5a5);
        wr(SPIO_REG_DIR, 16'h0000);
        rd(SPIO_REG_PORT, 16'ha5a5);
        chk(pad.oe, 16'hffff);
        rd(SPIO_REG_LAT, 16'ha5a5);
        wr(SPIO_REG_PORT, 16'h00ff);
        rd(SPIO_REG_LAT, 16'h00ff);
        wr(SPIO_REG_ODC, 16'hffff);
        ext_level = 16'h0f0f;
        rd(SPIO_REG_PORT, 16'h000f);
        chk(pad.oe, 16'hff00);
        wr(SPIO_REG_ODC, 16'h0000);
        periph = '{enable: 16'hffff, drive: 16'h0f0f, data: 16'h3333};
        rd(SPIO_REG_PORT, 16'h03f3);
        chk(pad.o, 16'h03f3);
        chk(periph_in & periph.drive, 16'h0303);
        periph = '0;
        wr(SPIO_REG_DIR, 16'hffff);
        ext_level = 16'hffff;
        asel_lo = 16'h00ff;
        rd(SPIO_REG_PORT, 16'h00ff);
        chk(analog_pin, 16'hff00);
        asel_hi = 16'hfff0;
        rd(SPIO_REG_PORT, 16'h00f0);
        chk(analog_pin, 16'hff0f);
        c1_off = 1'b1;
        rd(SPIO_REG_PORT, 16'hfff0);
        chk(analog_pin, 16'h000f);
        c2_off = 1'b1;
        rd(SPIO_REG_PORT, 16'hffff);
        chk(analog_pin, 16'h0000);
        c1_off = 1'b0;
        rd(SPIO_REG_PORT, 16'h00ff);
        chk(analog_pin, 16'hff00);
        // Analog pins stay inputs; the digital byte drives before a mid-run reset.
        wr(SPIO_REG_DIR, 16'hff00);
        rd(SPIO_REG_DIR, 16'hff00);
        chk(pad.oe, 16'h00ff);
        resetn = 1'b0;
        @(negedge core_clk);
        resetn = 1'b1;
        rd(SPIO_REG_DIR, DIR_RESET & IMPL_MASK);
        chk(pad.oe, 16'h0000);
        rd(SPIO_REG_LAT, LAT_RESET);
        wrap_up();
    end
endmodule // spio_port_tb
